// ==== rtl/dcx_map.vh ====
`ifndef DCX_MAP_VH
`define DCX_MAP_VH

// Register byte offsets
`define DCX_OFF_ERR_STATUS   4'h0
`define DCX_OFF_ERR_ADDR     4'h4
`define DCX_OFF_CRC_CONTROL  4'h8
`define DCX_OFF_IRQ_STATUS   4'hc

// Error status fields
`define DCX_ERR_DIR_BIT      31
`define DCX_ERR_CH_HI        2
`define DCX_ERR_CH_LO        0

// CRC control fields
`define DCX_BYTE_ORDER_SELECT_HI          29
`define DCX_BYTE_ORDER_SELECT_LO          28
`define DCX_WBO_BIT          27
`define DCX_REFLECT_ORDER_BIT         24
`define DCX_POLY_LENGTH_MINUS_ONE_HI          12
`define DCX_POLY_LENGTH_MINUS_ONE_LO          8
`define DCX_EN_BIT           7
`define DCX_APP_BIT          6
`define DCX_TYP_BIT          5
`define DCX_CH_HI            2
`define DCX_CH_LO            0
`define DCX_CTRL_WMASK       32'h3900_1fe7
`define DCX_CTRL_RESET       32'h0000_0000

// Interrupt status and mask, upper half is the mask
`define DCX_IRQ_ERR_BIT      0
`define DCX_IRQ_DONE_BIT     1
`define DCX_IRQ_MASK_LO      16

// Byte order codes
`define DCX_BYTE_ORDER_SELECT_NONE        2'h0
`define DCX_BYTE_ORDER_SELECT_WORD        2'h1
`define DCX_BYTE_ORDER_SELECT_HALF        2'h2
`define DCX_BYTE_ORDER_SELECT_HBYTE       2'h3

`endif

// ==== rtl/dcx_crc_engine.v ====
`include "dcx_map.vh"

module dcx_crc_engine (
    input  wire        core_clk,   // System clock
    input  wire        resetn,     // Sync reset, active low
    input  wire        clear,      // Reload seed
    input  wire [31:0] seed,       // Seed value
    input  wire        data_vld,   // Data word valid
    input  wire [31:0] data_in,    // Reordered data word
    input  wire [31:0] poly,       // Polynomial
    input  wire [4:0]  poly_length_minus_one_m1,    // Length minus one
    input  wire        reflect,    // LSb first
    input  wire        ip_mode,    // IP checksum mode
    output reg  [31:0] result_q    // Running result
);
    reg [31:0] lfsr_d;
    reg [31:0] cks_d;
    reg [31:0] top;
    reg [32:0] sum;
    reg [16:0] fold;
    reg        fb;
    reg [5:0]  b;
    reg [31:0] word;
    integer    i;

    always @* begin
        lfsr_d = result_q;
        top    = 32'h0000_0001 << poly_length_minus_one_m1;
        b      = 6'h00;
        fb     = 1'b0;
        word   = data_in;
        for (i = 0; i < 32; i = i + 1) begin
            b  = reflect ? i[5:0] : (6'd31 - i[5:0]);
            fb = word[b[4:0]] ^ (reflect ? lfsr_d[0] : |(lfsr_d & top));
            if (reflect) begin
                lfsr_d = (lfsr_d >> 1) ^ (fb ? poly : 32'h0000_0000);
            end else begin
                lfsr_d = ((lfsr_d << 1) ^ (fb ? poly : 32'h0000_0000)) & ((top << 1) - 32'h0000_0001);
            end
        end
        // Ones-complement sum of both half-words, bit order applied per half
        sum    = {17'h00000, result_q[15:0]} + {17'h00000, word[31:16]} + {17'h00000, word[15:0]};
        fold   = {1'b0, sum[15:0]} + {15'h0000, sum[17:16]};
        cks_d  = {16'h0000, fold[15:0] + {15'h0000, fold[16]}};
    end

    always @(posedge core_clk) begin
        if (!resetn) begin
            result_q <= 32'h0000_0000;
        end else if (clear) begin
            result_q <= seed;
        end else if (data_vld) begin
            result_q <= ip_mode ? cks_d : lfsr_d;
        end
    end
endmodule // dcx_crc_engine

// ==== rtl/dcx_top.v ====
`include "dcx_map.vh"

// Function
// RULE_01: Capture read or write direction on error
// RULE_02: Capture active channel number on error
// RULE_03: Capture bus address on error
// RULE_04: Byte order field selects CRC input order
// RULE_05: Write-reorder sends reordered data to destination
// RULE_06: Write-reorder blocks append bit and unaligned
// RULE_07: Type bit selects IP checksum or LFSR
// RULE_08: IP mode bit order reflected when set
// RULE_09: LFSR mode bit order reflected when set
// RULE_10: Length field is length minus one
// RULE_11: Enable routes channel transfers through CRC
// RULE_12: Unimplemented control bits read zero
// RULE_13: Channel field picks the routed channel
// RULE_14: Capture registers hold until next error
module dcx_top (
    input  wire        core_clk,        // System clock
    input  wire        resetn,          // Sync reset, active low
    input  wire [3:0]  avs_address,     // Byte address
    input  wire        avs_read,        // Read strobe
    input  wire        avs_write,       // Write strobe
    input  wire [31:0] avs_writedata,   // Write data
    input  wire [3:0]  avs_byteenable,  // Byte enables
    output reg  [31:0] avs_readdata,    // Read data
    output wire        avs_waitrequest, // Wait request
    output wire        irq,             // Level interrupt
    input  wire        dma_err,         // Bus error pulse
    input  wire        dma_err_is_read, // Errored access was a read
    input  wire [2:0]  dma_active_ch,   // Active channel
    input  wire [31:0] dma_bus_addr,    // Errored access address
    input  wire        xfer_vld,        // Transfer word valid
    input  wire [2:0]  xfer_ch,         // Channel of the word
    input  wire [31:0] xfer_data,       // Source word
    input  wire        xfer_unaligned,  // Word is unaligned
    output reg  [31:0] dest_data_q,     // Word to destination
    output reg         dest_vld_q,      // Destination word valid
    output reg         xfer_reject_q,   // Unaligned word refused
    input  wire        crc_clear,       // Reload CRC seed
    input  wire [31:0] crc_seed,        // Seed value
    input  wire [31:0] crc_poly,        // Polynomial
    output wire [31:0] crc_result,      // Running CRC
    output wire        crc_append_mode  // Append bit to DMA
);
    reg  [31:0] ctrl_q;
    reg         err_dir_q;
    reg  [2:0]  err_ch_q;
    reg  [31:0] err_addr_q;
    reg  [1:0]  irq_st_q;
    reg  [1:0]  irq_mask_q;
    reg         ack_q;
    reg  [31:0] ctrl_d;
    reg  [31:0] reord;
    wire [31:0] be_mask;
    wire        req;
    wire        routed;
    wire        crc_vld;
    wire        blocked;
    wire [1:0]  byte_order_select;

    assign req             = avs_read | avs_write;
    // Single wait cycle keeps read data registered
    assign avs_waitrequest = req & ~ack_q;
    assign be_mask         = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                              {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign byte_order_select            = ctrl_q[`DCX_BYTE_ORDER_SELECT_HI:`DCX_BYTE_ORDER_SELECT_LO];
    assign crc_append_mode = ctrl_q[`DCX_APP_BIT];
    assign irq             = |(irq_st_q & irq_mask_q);

    // RULE_13: channel match
    assign routed  = ctrl_q[`DCX_EN_BIT] & (xfer_ch == ctrl_q[`DCX_CH_HI:`DCX_CH_LO]);
    // RULE_06: refuse unaligned under reorder
    assign blocked = routed & ctrl_q[`DCX_WBO_BIT] & xfer_unaligned;
    // RULE_11: only routed words feed CRC
    assign crc_vld = xfer_vld & routed & ~blocked;

    // RULE_04: source byte order
    always @* begin
        case (byte_order_select)
            `DCX_BYTE_ORDER_SELECT_WORD:  reord = {xfer_data[7:0], xfer_data[15:8], xfer_data[23:16], xfer_data[31:24]};
            `DCX_BYTE_ORDER_SELECT_HALF:  reord = {xfer_data[15:0], xfer_data[31:16]};
            `DCX_BYTE_ORDER_SELECT_HBYTE: reord = {xfer_data[23:16], xfer_data[31:24], xfer_data[7:0], xfer_data[15:8]};
            default:         reord = xfer_data;
        endcase
    end

    always @* begin
        ctrl_d = (ctrl_q & ~(be_mask & `DCX_CTRL_WMASK)) | (avs_writedata & be_mask & `DCX_CTRL_WMASK);
        // RULE_06: append not settable with reorder
        if (ctrl_d[`DCX_WBO_BIT]) begin
            ctrl_d[`DCX_APP_BIT] = 1'b0;
        end
    end

    always @(posedge core_clk) begin
        if (!resetn) begin
            ack_q      <= 1'b0;
            ctrl_q     <= `DCX_CTRL_RESET;
            irq_mask_q <= 2'h0;
        end else begin
            ack_q <= req & ~ack_q;
            if (avs_write && ack_q && avs_address == `DCX_OFF_CRC_CONTROL) begin
                ctrl_q <= ctrl_d;
            end else if (avs_write && ack_q && avs_address == `DCX_OFF_IRQ_STATUS && avs_byteenable[2]) begin
                irq_mask_q <= avs_writedata[`DCX_IRQ_MASK_LO+1:`DCX_IRQ_MASK_LO];
            end
        end
    end

    always @(posedge core_clk) begin
        if (!resetn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack_q) begin
            if (avs_address == `DCX_OFF_ERR_STATUS) begin
                avs_readdata <= {err_dir_q, 28'h0000000, err_ch_q};
            end else if (avs_address == `DCX_OFF_ERR_ADDR) begin
                avs_readdata <= err_addr_q;
            end else if (avs_address == `DCX_OFF_CRC_CONTROL) begin
                // RULE_12: unimplemented bits zero
                avs_readdata <= ctrl_q & `DCX_CTRL_WMASK;
            end else if (avs_address == `DCX_OFF_IRQ_STATUS) begin
                avs_readdata <= {14'h0000, irq_mask_q, 14'h0000, irq_st_q};
            end else begin
                avs_readdata <= 32'h0000_0000;
            end
        end
    end

    // RULE_14: update only on error
    always @(posedge core_clk) begin
        if (!resetn) begin
            err_dir_q  <= 1'b0;
            err_ch_q   <= 3'h0;
            err_addr_q <= 32'h0000_0000;
        end else if (dma_err) begin
            // RULE_01: direction
            err_dir_q  <= dma_err_is_read;
            // RULE_02: channel
            err_ch_q   <= dma_active_ch;
            // RULE_03: address
            err_addr_q <= dma_bus_addr;
        end
    end

    // Set wins over write-one-to-clear
    always @(posedge core_clk) begin
        if (!resetn) begin
            irq_st_q <= 2'h0;
        end else begin
            irq_st_q <= (irq_st_q & ~((avs_write && ack_q && avs_address == `DCX_OFF_IRQ_STATUS
                                       && avs_byteenable[0]) ? avs_writedata[1:0] : 2'h0))
                        | {crc_vld, dma_err};
        end
    end

    always @(posedge core_clk) begin
        if (!resetn) begin
            dest_data_q   <= 32'h0000_0000;
            dest_vld_q    <= 1'b0;
            xfer_reject_q <= 1'b0;
        end else begin
            dest_vld_q    <= xfer_vld & ~blocked;
            xfer_reject_q <= xfer_vld & blocked;
            // Holds last delivered word so a late reader still sees it
            if (xfer_vld && !blocked) begin
                // RULE_05: reorder on write-back
                dest_data_q <= (routed && ctrl_q[`DCX_WBO_BIT]) ? reord : xfer_data;
            end
        end
    end

    // RULE_07: mode select
    // RULE_08: IP reflect
    // RULE_09: LFSR reflect
    // RULE_10: length used in LFSR only
    dcx_crc_engine u_crc (
        .core_clk (core_clk),
        .resetn   (resetn),
        .clear    (crc_clear),
        .seed     (crc_seed),
        .data_vld (crc_vld),
        .data_in  (ctrl_q[`DCX_REFLECT_ORDER_BIT] && ctrl_q[`DCX_TYP_BIT] ?
                   {reord[16], reord[17], reord[18], reord[19], reord[20], reord[21], reord[22], reord[23],
                    reord[24], reord[25], reord[26], reord[27], reord[28], reord[29], reord[30], reord[31],
                    reord[0], reord[1], reord[2], reord[3], reord[4], reord[5], reord[6], reord[7],
                    reord[8], reord[9], reord[10], reord[11], reord[12], reord[13], reord[14], reord[15]}
                   : reord),
        .poly     (crc_poly),
        .poly_length_minus_one_m1  (ctrl_q[`DCX_POLY_LENGTH_MINUS_ONE_HI:`DCX_POLY_LENGTH_MINUS_ONE_LO]),
        .reflect  (ctrl_q[`DCX_REFLECT_ORDER_BIT]),
        .ip_mode  (ctrl_q[`DCX_TYP_BIT]),
        .result_q (crc_result)
    );
endmodule // dcx_top

// ==== test/dcx_props.sv ====
module dcx_props (
    input wire logic        core_clk,        // Clock
    input wire logic        resetn,          // Reset
    input wire logic        avs_read,        // Read
    input wire logic        avs_write,       // Write
    input wire logic        avs_waitrequest, // Stall
    input wire logic        irq,             // Interrupt
    input wire logic        xfer_vld,        // Word in
    input wire logic        xfer_unaligned,  // Unaligned
    input wire logic        dest_vld_q,      // Word out
    input wire logic        xfer_reject_q,   // Refused
    input wire logic        crc_clear,       // Seed load
    input wire logic [31:0] crc_seed,        // Seed
    input wire logic [31:0] crc_result       // Result
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence rd_wait;
        avs_read && avs_waitrequest;
    endsequence
    sequence rd_done;
        avs_read && !avs_waitrequest;
    endsequence
    bus_ack_a: assert property (rd_wait |=> rd_done) else $error("read not acknowledged");
    bus_idle_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest) else $error("stall when idle");
    word_out_a: assert property (xfer_vld |=> dest_vld_q ^ xfer_reject_q) else $error("word lost");
    word_quiet_a: assert property (!xfer_vld |=> !dest_vld_q && !xfer_reject_q) else $error("spurious word");
    aligned_pass_a: assert property (xfer_vld && !xfer_unaligned |=> !xfer_reject_q) else $error("bad refusal");
    seed_load_a: assert property (crc_clear && !xfer_vld |=> crc_result == $past(crc_seed)) else $error("seed");
    crc_hold_a: assert property (!xfer_vld && !crc_clear |=> $stable(crc_result)) else $error("crc moved");
    irq_reset_a: assert property ($rose(resetn) |-> !irq) else $error("irq after reset");
endmodule // dcx_props

// ==== test/dcx_dma_model.sv ====
module dcx_dma_model (
    input  wire logic   core_clk,        // Clock
    output logic        dma_err,         // Error pulse
    output logic        dma_err_is_read, // Direction
    output logic [2:0]  dma_active_ch,   // Channel
    output logic [31:0] dma_bus_addr,    // Address
    output logic        xfer_vld,        // Word valid
    output logic [2:0]  xfer_ch,         // Word channel
    output logic [31:0] xfer_data,       // Word
    output logic        xfer_unaligned   // Unaligned
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {dma_err, dma_err_is_read, dma_active_ch, dma_bus_addr} = '0;
        {xfer_vld, xfer_ch, xfer_data, xfer_unaligned} = '0;
    end
    // Released lines flip so stale values never look valid
    task automatic err(input logic r, input logic [2:0] c, input logic [31:0] a);
        dma_err <= 1'b1;
        {dma_err_is_read, dma_active_ch, dma_bus_addr} <= {r, c, a};
        @(posedge core_clk);
        dma_err <= 1'b0;
        {dma_err_is_read, dma_active_ch, dma_bus_addr} <= ~{r, c, a};
        @(posedge core_clk);
    endtask
    task automatic word(input logic [2:0] c, input logic [31:0] d, input logic u);
        xfer_vld <= 1'b1;
        {xfer_ch, xfer_data, xfer_unaligned} <= {c, d, u};
        @(posedge core_clk);
        xfer_vld <= 1'b0;
        {xfer_ch, xfer_data, xfer_unaligned} <= ~{c, d, u};
        @(posedge core_clk);
    endtask
endmodule // dcx_dma_model

// ==== test/tb_dma_crc_and_error_capture.sv ====
module tb_dma_crc_and_error_capture;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, resetn, avs_read, avs_write, irq, avs_waitrequest, crc_clear, crc_append_mode;
    logic        dma_err, dma_err_is_read, xfer_vld, xfer_unaligned, dest_vld_q, xfer_reject_q;
    logic [3:0]  avs_address, avs_byteenable;
    logic [2:0]  dma_active_ch, xfer_ch, ch;
    logic [31:0] avs_writedata, avs_readdata, dma_bus_addr, xfer_data, dest_data_q, crc_seed, crc_poly;
    logic [31:0] crc_result, q, d, a;
    logic        r;
    int          error_cnt, checks, rej_cnt;
    dcx_top i_dut (.core_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .irq, .dma_err, .dma_err_is_read, .dma_active_ch, .dma_bus_addr,
        .xfer_vld, .xfer_ch, .xfer_data, .xfer_unaligned, .dest_data_q, .dest_vld_q, .xfer_reject_q,
        .crc_clear, .crc_seed, .crc_poly, .crc_result, .crc_append_mode);
    dcx_dma_model i_dma (.core_clk, .dma_err, .dma_err_is_read, .dma_active_ch, .dma_bus_addr,
        .xfer_vld, .xfer_ch, .xfer_data, .xfer_unaligned);
    // Refusal is a one-cycle pulse, counted away from the launching edge
    always @(negedge core_clk)
        if (xfer_reject_q === 1'b1)
            rej_cnt++;
    function automatic logic [31:0] csum(input logic [31:0] x);
        logic [17:0] s;
        s = 18'(x[31:16]) + 18'(x[15:0]);
        s = 18'(s[15:0]) + 18'(s[17:16]);
        s = 18'(s[15:0]) + 18'(s[16]);
        return {16'h0, s[15:0]};
    endfunction
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // Waits on waitrequest, never on a fixed latency
    task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        {avs_write, avs_read, avs_address, avs_writedata} <= {wr, !wr, ad, wd};
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 64);
        if (n >= 64)
            error_cnt++;
        rd = avs_readdata;
        {avs_write, avs_read} <= 2'b00;
        @(posedge core_clk);
    endtask
    function automatic logic [31:0] reord(input logic [1:0] m, input logic [31:0] x);
        case (m)
            2'h1: return {x[7:0], x[15:8], x[23:16], x[31:24]};
            2'h2: return {x[15:0], x[31:16]};
            2'h3: return {x[23:16], x[31:24], x[7:0], x[15:8]};
            default: return x;
        endcase
    endfunction
    function automatic logic [31:0] crc(input logic [31:0] c, input logic [31:0] p, input logic [31:0] x);
        for (int i = 31; i >= 0; i--)
            c = (c << 1) ^ ((c[31] ^ x[i]) ? p : 32'h0);
        return c;
    endfunction
    task automatic close_out();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        close_out();
    end
    initial begin
        {resetn, avs_read, avs_write, crc_clear} = 4'h0;
        {avs_address, avs_writedata, crc_seed, crc_poly} = '0;
        avs_byteenable = 4'hf;
        void'($urandom(32'h083bf582));
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, (i == 4) ? 4'h1 : 4'(i * 4), 32'h0, q);
            chk("reset value", 32'h0, q);
        end
        for (int i = 0; i < 4; i++) begin
            {r, ch, a} = {1'(i), 3'($urandom()), 32'($urandom())};
            i_dma.err(r, ch, a);
            bus(1'b0, 4'h0, 32'h0, q);
            chk("err status", {r, 28'h0, ch}, q);
            bus(1'b0, 4'h4, 32'h0, q);
            chk("err addr", a, q);
        end
        bus(1'b1, 4'h8, 32'hffff_ffff, q);
        bus(1'b0, 4'h8, 32'h0, q);
        chk("ctrl wbo", 32'h3900_1fa7, q);
        bus(1'b1, 4'h8, 32'h0000_1fe7, q);
        bus(1'b0, 4'h8, 32'h0, q);
        chk("ctrl", 32'h0000_1fe7, q);
        chk("append", 32'h1, 32'(crc_append_mode));
        // Interrupt raised by the earlier errors, masked, then cleared
        chk("irq masked", 32'h0, 32'(irq));
        bus(1'b1, 4'hc, 32'h0001_0000, q);
        chk("irq", 32'h1, 32'(irq));
        bus(1'b1, 4'hc, 32'h0001_0001, q);
        chk("irq clear", 32'h0, 32'(irq));
        for (int m = 0; m < 4; m++) begin
            {ch, d} = {3'($urandom()), 32'($urandom())};
            bus(1'b1, 4'h8, {2'h0, 2'(m), 28'h800_0080} | 32'(ch), q);
            i_dma.word(ch, d, 1'b0);
            chk("reorder", reord(2'(m), d), dest_data_q);
            i_dma.word(ch + 3'h1, d, 1'b0);
            chk("other ch", d, dest_data_q);
            i_dma.word(ch, d, 1'b1);
            chk("unaligned", 32'(m + 1), 32'(rej_cnt));
        end
        bus(1'b1, 4'h8, 32'h1000_0080 | 32'(ch), q);
        i_dma.word(ch, d, 1'b0);
        chk("no write back", d, dest_data_q);
        {a, crc_seed, crc_poly, crc_clear} <= {32'($urandom()), 32'($urandom()), 32'($urandom()) | 32'h1, 1'b1};
        bus(1'b1, 4'h8, 32'h0000_1f80 | 32'(ch), q);
        crc_clear <= 1'b0;
        q = crc_result;
        i_dma.word(ch, a, 1'b0);
        chk("lfsr", crc(q, crc_poly, a), crc_result);
        bus(1'b1, 4'h8, 32'h0, q);
        q = crc_result;
        i_dma.word(ch, d, 1'b0);
        chk("crc off", q, crc_result);
        {crc_seed, crc_clear} <= {32'h0, 1'b1};
        bus(1'b1, 4'h8, 32'h0000_00a0 | 32'(ch), q);
        crc_clear <= 1'b0;
        i_dma.word(ch, d, 1'b0);
        chk("ip sum", csum(d), crc_result);
        close_out();
    end
endmodule // tb_dma_crc_and_error_capture
bind dcx_top dcx_props i_props (.core_clk(core_clk), .resetn(resetn), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .irq(irq), .xfer_vld(xfer_vld),
    .xfer_unaligned(xfer_unaligned), .dest_vld_q(dest_vld_q), .xfer_reject_q(xfer_reject_q),
    .crc_clear(crc_clear), .crc_seed(crc_seed), .crc_result(crc_result));
